// ### rtl/sfe_consts.svh
// constants for the serial flash erase sequencer
`ifndef SFE_CONSTS_SVH
`define SFE_CONSTS_SVH

// opcodes and the four-byte whole-array sequence
`define SFE_OP_PAGE 8'h81
`define SFE_OP_BLOCK 8'h50
`define SFE_OP_SECTOR 8'h7C
`define SFE_CHIP_SEQ 32'hC794_809A

// frame shape: one opcode byte plus three address bytes
`define SFE_FRAME_W 32
`define SFE_OP_LSB 24
`define SFE_BIT_CNT_W 6
`define SFE_LAST_BIT 6'h1F
`define SFE_FRAME_FULL 6'h20

// page field inside the 24-bit address, per page-size mode
`define SFE_PAGE_W 9
`define SFE_ADDR_W 24
`define SFE_STD_PAGE_LSB 9
`define SFE_BIN_PAGE_LSB 8
`define SFE_LAST_PAGE 9'h1FF
`define SFE_BLOCK_LOW 3'h0
`define SFE_BLOCK_HIGH 3'h7
`define SFE_SEC_TOP_LOW 7'h00
`define SFE_SEC0A_LAST 9'h007
`define SFE_SEC0B_FIRST 9'h008
`define SFE_SEC0B_LAST 9'h07F
`define SFE_SECT_W 5

// erase times in ns, plain defaults; the core clock period in ns
`define SFE_T_PE_NS 20000
`define SFE_T_BE_NS 40000
`define SFE_T_SE_NS 400000
`define SFE_T_CE_NS 2000000
`define SFE_CORE_CLK_NS 4

// host link timing in core cycles
`define SFE_SCK_HALF 8'h06
`define SFE_CS_HIGH 8'h10
`define SFE_TIMER_W 32

`endif

// ### rtl/sfe_pkg.sv
// types shared by both ends of the erase link
package sfe_pkg;
    typedef enum logic [1:0] {
        SFE_KIND_PAGE = 2'b00,
        SFE_KIND_BLOCK = 2'b01,
        SFE_KIND_SECTOR = 2'b10,
        SFE_KIND_CHIP = 2'b11
    } sfe_kind_t;

    // bit index into the five-entry sector protect mask
    typedef enum logic [2:0] {
        SFE_SEC_0A = 3'b000,
        SFE_SEC_0B = 3'b001,
        SFE_SEC_1 = 3'b010,
        SFE_SEC_2 = 3'b011,
        SFE_SEC_3 = 3'b100
    } sfe_sector_t;

    typedef enum logic [1:0] {
        SFE_DEV_IDLE = 2'b00,
        SFE_DEV_WALK = 2'b01,
        SFE_DEV_WAIT = 2'b10
    } sfe_dev_state_t;

    typedef enum logic [1:0] {
        SFE_HOST_IDLE = 2'b00,
        SFE_HOST_SHIFT = 2'b01,
        SFE_HOST_GAP = 2'b10
    } sfe_host_state_t;
endpackage

// ### rtl/sfe_link_if.sv
// serial link between the erase host and the flash device
`timescale 1ns/1ps
interface sfe_link_if;
    logic sck;
    logic cs_n;
    logic si;
    logic wp_n;
    logic so;
    logic so_oe;
    logic so_line;

    // output pin idles high when the device does not drive it
    assign so_line = so_oe ? so : 1'b1;

    modport dev (
        input sck,
        input cs_n,
        input si,
        input wp_n,
        output so,
        output so_oe
    );

    modport host (
        output sck,
        output cs_n,
        output si,
        output wp_n,
        input so_line
    );
endinterface

// ### rtl/sfe_host.sv
// host end: builds erase frames and drives the serial link
`timescale 1ns/1ps
`include "sfe_consts.svh"
module sfe_host (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_start,
    input wire sfe_pkg::sfe_kind_t i_kind,
    input wire logic [`SFE_PAGE_W-1:0] i_page,
    input wire logic i_binary,
    input wire logic i_wp_n,
    sfe_link_if.host link,
    output logic o_busy,
    output logic o_done,
    output logic o_dev_ready
);
    sfe_pkg::sfe_host_state_t state;
    logic [`SFE_FRAME_W-1:0] frame;
    logic [`SFE_FRAME_W-1:0] next_frame;
    logic [`SFE_PAGE_W-1:0] page_m;
    logic [`SFE_ADDR_W-1:0] addr;
    logic [7:0] div;
    logic [`SFE_BIT_CNT_W-1:0] bits;
    logic so_s1;
    logic so_s2;
    logic wp_q;

    // block and sector commands send their low three page bits as zero, the low seven for upper sectors
    always_comb begin
        case (i_kind)
            sfe_pkg::SFE_KIND_BLOCK: page_m = {i_page[8:3], `SFE_BLOCK_LOW};
            sfe_pkg::SFE_KIND_SECTOR: begin
                if (i_page[8:7] != 2'b00) begin
                    page_m = {i_page[8:7], `SFE_SEC_TOP_LOW};
                end else begin
                    page_m = {i_page[8:3], `SFE_BLOCK_LOW};
                end
            end
            default: page_m = i_page;
        endcase
    end

    // page field sits lower by one bit in binary mode
    always_comb begin
        if (i_binary) begin
            addr = `SFE_ADDR_W'(page_m) << `SFE_BIN_PAGE_LSB;
        end else begin
            addr = `SFE_ADDR_W'(page_m) << `SFE_STD_PAGE_LSB;
        end
        case (i_kind)
            sfe_pkg::SFE_KIND_PAGE: next_frame = {`SFE_OP_PAGE, addr};
            sfe_pkg::SFE_KIND_BLOCK: next_frame = {`SFE_OP_BLOCK, addr};
            sfe_pkg::SFE_KIND_SECTOR: next_frame = {`SFE_OP_SECTOR, addr};
            default: next_frame = `SFE_CHIP_SEQ;
        endcase
    end

    // frame sequencer: sck idles low, si changes on falling edges
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= sfe_pkg::SFE_HOST_IDLE;
            frame <= '0;
            div <= 8'h00;
            bits <= '0;
            link.sck <= 1'b0;
            link.cs_n <= 1'b1;
            link.si <= 1'b0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            case (state)
                sfe_pkg::SFE_HOST_IDLE: begin
                    if (i_start) begin
                        frame <= next_frame;
                        link.si <= next_frame[`SFE_FRAME_W-1];
                        link.cs_n <= 1'b0;
                        div <= `SFE_SCK_HALF;
                        bits <= '0;
                        o_busy <= 1'b1;
                        state <= sfe_pkg::SFE_HOST_SHIFT;
                    end
                end
                sfe_pkg::SFE_HOST_SHIFT: begin
                    if (div != 8'h00) begin
                        div <= div - 8'h01;
                    end else begin
                        div <= `SFE_SCK_HALF;
                        if (bits == `SFE_FRAME_FULL && !link.sck) begin
                            // cs rises only after the last bit's falling edge
                            link.cs_n <= 1'b1;
                            div <= `SFE_CS_HIGH;
                            state <= sfe_pkg::SFE_HOST_GAP;
                        end else if (!link.sck) begin
                            link.sck <= 1'b1;
                            bits <= bits + `SFE_BIT_CNT_W'(1);
                        end else begin
                            link.sck <= 1'b0;
                            frame <= {frame[`SFE_FRAME_W-2:0], 1'b0};
                            link.si <= frame[`SFE_FRAME_W-2];
                        end
                    end
                end
                sfe_pkg::SFE_HOST_GAP: begin
                    // keeps cs high long enough for the device to see the edge
                    if (div != 8'h00) begin
                        div <= div - 8'h01;
                    end else begin
                        o_busy <= 1'b0;
                        o_done <= 1'b1;
                        state <= sfe_pkg::SFE_HOST_IDLE;
                    end
                end
                default: state <= sfe_pkg::SFE_HOST_IDLE;
            endcase
        end
    end

    // write protect pin follows the user input
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wp_q <= 1'b1;
        end else begin
            wp_q <= i_wp_n;
        end
    end
    assign link.wp_n = wp_q;

    // device ready level arrives from the other domain
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            so_s1 <= 1'b1;
            so_s2 <= 1'b1;
            o_dev_ready <= 1'b1;
        end else begin
            so_s1 <= link.so_line;
            so_s2 <= so_s1;
            o_dev_ready <= so_s2;
        end
    end
endmodule

// ### rtl/sfe_device.sv
// device end: erase command decode and self-timed erase sequencer
`timescale 1ns/1ps
`include "sfe_consts.svh"
// How it works
// - standard page erase: 81H, page bits high
// - binary page erase: page from A16 down A8
// - page erase sets page to ones, busy
// - standard block erase: 50H, six block bits
// - binary block erase: A16 down to A11
// - block is eight pages, low bits ignored
// - block erase self-timed, busy until done
// - 7CH erases exactly one of five sectors
// - standard sector address from top page bits
// - binary sector address from A16 down
// - sector decode: top bits, then page bit three
// - sector erase self-timed, busy throughout
// - only exact C7 94 80 9A erases array
// - no address; extra bits ignored; starts cs rise
// - array erase skips protected sectors
// - protect pin change waits for erase end
// - array erase busy until time elapsed
// - host holds cs low over whole command
module sfe_device #(
    parameter int T_PE_NS = `SFE_T_PE_NS,
    parameter int T_BE_NS = `SFE_T_BE_NS,
    parameter int T_SE_NS = `SFE_T_SE_NS,
    parameter int T_CE_NS = `SFE_T_CE_NS
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_binary,
    input wire logic i_sw_protect,
    input wire logic [`SFE_SECT_W-1:0] i_prot_mask,
    sfe_link_if.dev link,
    output logic o_busy,
    output logic o_done,
    output logic o_erase_pulse,
    output logic [`SFE_PAGE_W-1:0] o_erase_page
);
    // all four erase times round down to whole core cycles
    localparam logic [`SFE_TIMER_W-1:0] PE_CYC = `SFE_TIMER_W'(T_PE_NS / `SFE_CORE_CLK_NS);
    localparam logic [`SFE_TIMER_W-1:0] BE_CYC = `SFE_TIMER_W'(T_BE_NS / `SFE_CORE_CLK_NS);
    localparam logic [`SFE_TIMER_W-1:0] SE_CYC = `SFE_TIMER_W'(T_SE_NS / `SFE_CORE_CLK_NS);
    localparam logic [`SFE_TIMER_W-1:0] CE_CYC = `SFE_TIMER_W'(T_CE_NS / `SFE_CORE_CLK_NS);

    // link domain
    logic [`SFE_FRAME_W-1:0] shift;
    logic [`SFE_FRAME_W-1:0] next_shift;
    logic [`SFE_BIT_CNT_W-1:0] bit_cnt;
    logic [`SFE_FRAME_W-1:0] hold;
    logic cmd_tgl;
    logic op_ok;
    // core domain
    logic cs_s1;
    logic cs_s2;
    logic cs_prev;
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_prev;
    logic armed;
    logic cs_rise;
    logic cs_fall;
    sfe_pkg::sfe_dev_state_t state;
    sfe_pkg::sfe_kind_t kind;
    sfe_pkg::sfe_kind_t next_kind;
    logic [`SFE_PAGE_W-1:0] cur;
    logic [`SFE_PAGE_W-1:0] last;
    logic [`SFE_PAGE_W-1:0] sel_page;
    logic [`SFE_PAGE_W-1:0] next_first;
    logic [`SFE_PAGE_W-1:0] next_last;
    logic [`SFE_TIMER_W-1:0] next_time;
    logic [`SFE_TIMER_W-1:0] timer;
    logic [`SFE_SECT_W-1:0] prot_snap;
    logic wp_s1;
    logic wp_s2;

    // sector index of a page: top bits first, then page bit three
    function automatic sfe_pkg::sfe_sector_t sector_of(input logic [`SFE_PAGE_W-1:0] p);
        sfe_pkg::sfe_sector_t s;
        s = sfe_pkg::SFE_SEC_0A;
        case (p[8:7])
            2'b01: s = sfe_pkg::SFE_SEC_1;
            2'b10: s = sfe_pkg::SFE_SEC_2;
            2'b11: s = sfe_pkg::SFE_SEC_3;
            default: s = p[3] ? sfe_pkg::SFE_SEC_0B : sfe_pkg::SFE_SEC_0A;
        endcase
        return s;
    endfunction

    assign next_shift = {shift[`SFE_FRAME_W-2:0], link.si};

    // accepted opcodes; whole frame compared for the array sequence
    always_comb begin
        case (next_shift[`SFE_FRAME_W-1:`SFE_OP_LSB])
            `SFE_OP_PAGE: op_ok = 1'b1;
            `SFE_OP_BLOCK: op_ok = 1'b1;
            `SFE_OP_SECTOR: op_ok = 1'b1;
            default: op_ok = (next_shift == `SFE_CHIP_SEQ);
        endcase
    end

    // bit counter restarts whenever cs is high between frames
    always_ff @(posedge link.sck or posedge link.cs_n) begin
        if (link.cs_n) begin
            bit_cnt <= '0;
            shift <= '0;
        end else if (bit_cnt != `SFE_FRAME_FULL) begin
            shift <= next_shift;
            bit_cnt <= bit_cnt + `SFE_BIT_CNT_W'(1);
        end
    end

    // a complete frame is handed over by toggle; bits past it are dropped
    always_ff @(posedge link.sck or negedge i_nrst) begin
        if (!i_nrst) begin
            hold <= '0;
            cmd_tgl <= 1'b0;
        end else if (!link.cs_n && bit_cnt == `SFE_LAST_BIT && op_ok) begin
            hold <= next_shift;
            cmd_tgl <= ~cmd_tgl;
        end
    end

    // cs, toggle and protect pin cross into the core domain
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_prev <= 1'b1;
            tgl_s1 <= 1'b0;
            tgl_s2 <= 1'b0;
            tgl_prev <= 1'b0;
            wp_s1 <= 1'b1;
            wp_s2 <= 1'b1;
        end else begin
            cs_s1 <= link.cs_n;
            cs_s2 <= cs_s1;
            cs_prev <= cs_s2;
            tgl_s1 <= cmd_tgl;
            tgl_s2 <= tgl_s1;
            tgl_prev <= tgl_s2;
            wp_s1 <= link.wp_n;
            wp_s2 <= wp_s1;
        end
    end

    assign cs_rise = cs_s2 && !cs_prev;
    assign cs_fall = !cs_s2 && cs_prev;

    // armed only by a full frame inside the current cs-low window
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            armed <= 1'b0;
        end else if (tgl_s2 != tgl_prev) begin
            armed <= 1'b1;
        end else if (cs_fall || cs_rise) begin
            armed <= 1'b0;
        end
    end

    // decode of the held frame into kind, page range and time
    always_comb begin
        if (i_binary) begin
            sel_page = hold[`SFE_BIN_PAGE_LSB +: `SFE_PAGE_W];
        end else begin
            sel_page = hold[`SFE_STD_PAGE_LSB +: `SFE_PAGE_W];
        end
        next_kind = sfe_pkg::SFE_KIND_CHIP;
        next_first = '0;
        next_last = `SFE_LAST_PAGE;
        next_time = CE_CYC;
        case (hold[`SFE_FRAME_W-1:`SFE_OP_LSB])
            `SFE_OP_PAGE: begin
                next_kind = sfe_pkg::SFE_KIND_PAGE;
                next_first = sel_page;
                next_last = sel_page;
                next_time = PE_CYC;
            end
            `SFE_OP_BLOCK: begin
                next_kind = sfe_pkg::SFE_KIND_BLOCK;
                next_first = {sel_page[8:3], `SFE_BLOCK_LOW};
                next_last = {sel_page[8:3], `SFE_BLOCK_HIGH};
                next_time = BE_CYC;
            end
            `SFE_OP_SECTOR: begin
                next_kind = sfe_pkg::SFE_KIND_SECTOR;
                next_time = SE_CYC;
                case (sector_of(sel_page))
                    sfe_pkg::SFE_SEC_0A: begin
                        next_first = '0;
                        next_last = `SFE_SEC0A_LAST;
                    end
                    sfe_pkg::SFE_SEC_0B: begin
                        next_first = `SFE_SEC0B_FIRST;
                        next_last = `SFE_SEC0B_LAST;
                    end
                    default: begin
                        next_first = {sel_page[8:7], `SFE_SEC_TOP_LOW};
                        next_last = {sel_page[8:7], ~`SFE_SEC_TOP_LOW};
                    end
                endcase
            end
            default: begin
                next_kind = sfe_pkg::SFE_KIND_CHIP;
            end
        endcase
    end

    // erase sequencer: one page strobe a cycle, then waits out the time
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= sfe_pkg::SFE_DEV_IDLE;
            kind <= sfe_pkg::SFE_KIND_PAGE;
            cur <= '0;
            last <= '0;
            timer <= '0;
            prot_snap <= '0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_erase_pulse <= 1'b0;
            o_erase_page <= '0;
        end else begin
            o_done <= 1'b0;
            o_erase_pulse <= 1'b0;
            case (state)
                sfe_pkg::SFE_DEV_IDLE: begin
                    // only idle accepts a launch, so busy drops new commands
                    if (cs_rise && armed) begin
                        kind <= next_kind;
                        cur <= next_first;
                        last <= next_last;
                        timer <= next_time;
                        // protection frozen here; pin changes wait for the end
                        prot_snap <= (!wp_s2 || i_sw_protect) ? i_prot_mask : '0;
                        o_busy <= 1'b1;
                        state <= sfe_pkg::SFE_DEV_WALK;
                    end
                end
                sfe_pkg::SFE_DEV_WALK: begin
                    timer <= timer - `SFE_TIMER_W'(1);
                    o_erase_page <= cur;
                    o_erase_pulse <= !(kind == sfe_pkg::SFE_KIND_CHIP
                                       && prot_snap[sector_of(cur)]);
                    if (cur == last) begin
                        state <= sfe_pkg::SFE_DEV_WAIT;
                    end else begin
                        cur <= cur + `SFE_PAGE_W'(1);
                    end
                end
                sfe_pkg::SFE_DEV_WAIT: begin
                    // timer runs from the launch, walk included
                    if (timer == '0) begin
                        o_busy <= 1'b0;
                        o_done <= 1'b1;
                        state <= sfe_pkg::SFE_DEV_IDLE;
                    end else begin
                        timer <= timer - `SFE_TIMER_W'(1);
                    end
                end
                default: state <= sfe_pkg::SFE_DEV_IDLE;
            endcase
        end
    end

    // ready status on the output pin while selected
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            link.so <= 1'b1;
            link.so_oe <= 1'b0;
        end else begin
            link.so <= !o_busy;
            link.so_oe <= !cs_s2;
        end
    end
endmodule

// ### tb/sfe_link_props.sv
// checker for the erase link: host framing and device status pin behaviour
`timescale 1ns/1ps
module sfe_link_props (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic wp_n,
    input wire logic so,
    input wire logic so_oe,
    input wire logic so_line
);
    logic sck_d;
    logic [6:0] rise_cnt;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);

    // link clock rises inside the current select window; cleared while deselected
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sck_d <= 1'b0;
            rise_cnt <= 7'h00;
        end else begin
            sck_d <= sck;
            if (cs_n) begin
                rise_cnt <= 7'h00;
            end else if (sck && !sck_d) begin
                rise_cnt <= rise_cnt + 7'h01;
            end
        end
    end

    a_sck_idle_deselect: assert property (cs_n |-> !sck)
        else $error("link clock moved while deselected");
    a_select_lead: assert property ($fell(cs_n) |-> !sck [*6] ##[1:2] sck)
        else $error("first link clock rise not one half period after select");
    a_sck_high_half: assert property ($rose(sck) |-> sck [*6] ##[1:2] !sck)
        else $error("link clock high phase has wrong length");
    a_si_stable_high: assert property (sck |-> $stable(si))
        else $error("serial data changed while link clock high");
    a_frame_bits: assert property ($rose(cs_n) |-> rise_cnt == 7'h20)
        else $error("frame did not carry exactly 32 bits");
    a_deselect_gap: assert property ($rose(cs_n) |-> cs_n [*8])
        else $error("deselect gap too short");
    a_oe_release: assert property ($rose(cs_n) |-> ##[0:5] !so_oe)
        else $error("status pin still driven after deselect");
    a_oe_drive: assert property ($fell(cs_n) |-> ##[1:5] so_oe)
        else $error("status pin not driven after select");

    // main scenarios: complete frame, busy seen on the pin, protect pin asserted
    c_full_frame: cover property ($rose(cs_n) && rise_cnt == 7'h20);
    c_busy_seen: cover property (so_oe && !so && so_line == so);
    c_wp_low: cover property ($fell(wp_n));
endmodule

// ### tb/testbench.sv
// bench: host and device ends face to face, plus a device fed by raw frames
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench;
    localparam int T_NS = 4000;
    logic i_core_clk, i_nrst, start, bin, sw_prot, wp_n_in, r_sck, r_cs_n, r_si;
    logic h_busy, h_done, h_ready, d_busy, d_done, d_pulse, d2_busy, d2_done;
    sfe_pkg::sfe_kind_t kind;
    logic [8:0] page, d_page, first_pg, last_pg;
    logic [4:0] mask;
    int n_pulse, miscompares, n_checks, i;

    sfe_link_if link ();
    sfe_link_if link_raw ();
    // raw link: sck stands still outside frames, wp never asserted
    assign link_raw.sck = r_sck;
    assign link_raw.cs_n = r_cs_n;
    assign link_raw.si = r_si;
    assign link_raw.wp_n = 1'b1;

    sfe_host u_sfe_host (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_start(start),
        .i_kind(kind), .i_page(page), .i_binary(bin), .i_wp_n(wp_n_in), .link(link),
        .o_busy(h_busy), .o_done(h_done), .o_dev_ready(h_ready));
    sfe_device #(.T_PE_NS(T_NS), .T_BE_NS(T_NS), .T_SE_NS(T_NS), .T_CE_NS(T_NS)) u_sfe_device (
        .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_binary(bin), .i_sw_protect(sw_prot),
        .i_prot_mask(mask), .link(link), .o_busy(d_busy), .o_done(d_done),
        .o_erase_pulse(d_pulse), .o_erase_page(d_page));
    sfe_device #(.T_PE_NS(T_NS), .T_BE_NS(T_NS), .T_SE_NS(T_NS), .T_CE_NS(T_NS))
        u_sfe_device_raw (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_binary(bin),
        .i_sw_protect(1'b0), .i_prot_mask(5'h00), .link(link_raw), .o_busy(d2_busy),
        .o_done(d2_done), .o_erase_pulse(), .o_erase_page());
    sfe_link_props u_sfe_link_props (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
        .sck(link.sck), .cs_n(link.cs_n), .si(link.si), .wp_n(link.wp_n), .so(link.so),
        .so_oe(link.so_oe), .so_line(link.so_line));

    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end

    // erased pages as the device reports them; sampled mid-cycle where pulse and page are settled
    always @(negedge i_core_clk) begin
        if (d_pulse === 1'b1) begin
            if (n_pulse == 0) first_pg = d_page;
            last_pg = d_page;
            n_pulse++;
        end
    end

    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // bounded wait for a flag; running out counts as a mismatch
    task automatic wait_hi(ref logic s, input int lim);
        for (int k = 0; k < lim && s !== 1'b1; k++) @(negedge i_core_clk);
        `CHK(s, 1'b1)
    endtask

    task kick(input sfe_pkg::sfe_kind_t k, input logic [8:0] p);
        @(negedge i_core_clk);
        kind = k;
        page = p;
        start = 1'b1;
        @(negedge i_core_clk);
        start = 1'b0;
    endtask

    task go(input sfe_pkg::sfe_kind_t k, input logic [8:0] p);
        n_pulse = 0;
        kick(k, p);
        `CHK(h_busy, 1'b1)
        wait_hi(h_done, 1000);
        `CHK(h_busy, 1'b0)
    endtask

    task fin(input logic [8:0] f, input logic [8:0] l, input int c);
        `CHK(d_busy, 1'b1)
        wait_hi(d_done, 1200);
        `CHK(d_busy, 1'b0)
        `CHK(n_pulse, c)
        `CHK(first_pg, f)
        `CHK(last_pg, l)
        $display("test ended: %0d pages erased", n_pulse);
    endtask

    // one byte MSB first at a 48 ns link period; sck only runs inside the frame
    task raw_byte(input logic [7:0] b);
        for (int k = 7; k >= 0; k--) begin
            r_sck = 1'b0;
            r_si = b[k];
            repeat (6) @(negedge i_core_clk);
            r_sck = 1'b1;
            repeat (6) @(negedge i_core_clk);
        end
    endtask

    // released data line shows the inverse of its last bit
    task raw_end;
        r_sck = 1'b0;
        repeat (6) @(negedge i_core_clk);
        r_cs_n = 1'b1;
        r_si = ~r_si;
        repeat (20) @(negedge i_core_clk);
    endtask

    task raw_cmd(input logic [31:0] w);
        @(negedge i_core_clk);
        r_cs_n = 1'b0;
        for (int k = 3; k >= 0; k--) raw_byte(w[8*k +: 8]);
    endtask

    initial begin
        {start, bin, sw_prot, r_sck, r_si, i_nrst, n_pulse, miscompares, n_checks} = '0;
        {wp_n_in, r_cs_n} = 2'b11;
        kind = sfe_pkg::SFE_KIND_PAGE;
        page = 9'h000;
        mask = 5'h00;
        repeat (10) @(negedge i_core_clk);
        i_nrst = 1'b1;
        go(sfe_pkg::SFE_KIND_PAGE, 9'h1A5); fin(9'h1A5, 9'h1A5, 1);
        go(sfe_pkg::SFE_KIND_BLOCK, 9'h0FD); fin(9'h0F8, 9'h0FF, 8);
        go(sfe_pkg::SFE_KIND_SECTOR, 9'h005); fin(9'h000, 9'h007, 8);
        go(sfe_pkg::SFE_KIND_SECTOR, 9'h00C); fin(9'h008, 9'h07F, 120);
        bin = 1'b1;
        go(sfe_pkg::SFE_KIND_PAGE, 9'h003); fin(9'h003, 9'h003, 1);
        go(sfe_pkg::SFE_KIND_BLOCK, 9'h1FF); fin(9'h1F8, 9'h1FF, 8);
        for (i = 1; i < 4; i++) begin
            go(sfe_pkg::SFE_KIND_SECTOR, {i[1:0], 7'h15});
            fin({i[1:0], 7'h00}, {i[1:0], 7'h7F}, 128);
        end
        // chip erase with software protection, then with the protect pin
        sw_prot = 1'b1;
        mask = 5'h04;
        go(sfe_pkg::SFE_KIND_CHIP, 9'h000); fin(9'h000, 9'h1FF, 384);
        sw_prot = 1'b0;
        wp_n_in = 1'b0;
        mask = 5'h10;
        go(sfe_pkg::SFE_KIND_CHIP, 9'h000); fin(9'h000, 9'h17F, 384);
        // pin asserted only once the erase runs: nothing is spared
        wp_n_in = 1'b1;
        mask = 5'h03;
        go(sfe_pkg::SFE_KIND_CHIP, 9'h000);
        wp_n_in = 1'b0;
        fin(9'h000, 9'h1FF, 512);
        wp_n_in = 1'b1;
        // second command while busy: status shows busy, command dropped
        go(sfe_pkg::SFE_KIND_PAGE, 9'h010);
        kick(sfe_pkg::SFE_KIND_PAGE, 9'h020);
        repeat (100) @(negedge i_core_clk);
        `CHK(h_ready, 1'b0)
        wait_hi(h_done, 1000);
        fin(9'h010, 9'h010, 1);
        repeat (30) @(negedge i_core_clk);
        `CHK(d_busy, 1'b0)
        // raw frames: short, wrong sequence, correct sequence with trailing bits
        @(negedge i_core_clk);
        r_cs_n = 1'b0;
        raw_byte(8'h81);
        raw_byte(8'h00);
        raw_end;
        `CHK(d2_busy, 1'b0)
        raw_cmd(32'hC794_809B);
        raw_end;
        `CHK(d2_busy, 1'b0)
        raw_cmd(32'hC794_809A);
        raw_byte(8'hFF);
        raw_end;
        `CHK(d2_busy, 1'b1)
        wait_hi(d2_done, 1200);
        $display("test ended: raw frames");
        end_sim;
    end

    // watchdog sized well above the roughly 21k cycles the tests need
    initial begin
        #200000;
        miscompares++;
        $display("watchdog expired");
        end_sim;
    end
endmodule
